// ### hdl/eight_line_async_mux_regs.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Received-character silo with shift-down behaviour.
module rx_silo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 64
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic flush,
	// Fill side.
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side.
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int CW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [CW-1:0] count_reg;
	logic push;
	logic pop;

	assign in_ready = (count_reg != CW'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign out_data = mem_reg[0];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_ff @(posedge clk_sys) begin
		if (flush) begin
			count_reg <= '0;
		end else begin
			count_reg <= CW'(count_reg + CW'(push) - CW'(pop));
		end
	end

	// Entries shift down on a pop; a push lands just above the last entry.
	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < DEPTH; i++) begin
			if (pop && i < DEPTH - 1) begin
				mem_reg[i] <= mem_reg[i + 1];
			end
			if (push && CW'(i) == (pop ? CW'(count_reg - 1'b1) : count_reg)) begin
				mem_reg[i] <= in_data;
			end
		end
	end
endmodule : rx_silo

// How it works
// - Silo holds 64 entries of 16 bits.
// - Entry keeps character, line number, error bits.
// - Push in phase 2 when ready and available.
// - Pop only when silo has data and read.
// - Register 2 read gives oldest; advance after read.
// - Character 7:0, line 10:8, errors 15:12.
// - Baud select bits 11:8 latched by control strobe.
// - Bit 12 per line gates receive clock.
// - Receive and transmit share one baud rate.
// - Line parameters write-only at register 2.
// - Parameter write holds off slave sync 500 ns.
// - Control strobe fires midway through hold-off.
// - Status keeps bits 3-6, 12, 14; reset clears.
// - Status accepts byte or word writes.
// - Six registers across four addresses.
// - Transmit control: enables low, ready flags high.
// - Reset pulse clears enables; init clears ready flags.
// - Modem status live, read-only, no interrupts.
// - Transmit data: character low, break high.
// - Break bit forces line output to zero.
// - Per-line receive, transmit run independently.
// - Device reset pulse lasts 15 us.
// - Scanner slot 4 us, four equal phases.
module eight_line_async_mux_regs
	import mux_regs_pkg::*;
#(
	parameter int LINES = mux_regs_pkg::NUM_LINES,
	parameter int DEPTH = mux_regs_pkg::SILO_DEPTH
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Register port.
	input wire logic [2:0] reg_addr,
	input wire logic bus_read,
	input wire logic bus_write,
	input wire logic [1:0] byte_en,
	input wire logic [15:0] wr_data,
	output logic [15:0] rd_data,
	output logic bus_slave_sync,
	input wire logic bus_init,
	// Scanner and receivers.
	output logic [2:0] scan_line,
	input wire logic rx_data_available,
	input wire logic [7:0] rx_char,
	input wire logic [3:0] rx_errors,
	output logic fifo_push,
	output logic rx_avail_clear,
	// Line parameters and baud clocks.
	output logic [15:0] line_parameters,
	output logic [LINES-1:0] param_strobe,
	output logic [LINES-1:0] tx_baud_clock,
	output logic [LINES-1:0] rx_baud_clock,
	// Transmit side.
	output logic [LINES-1:0] tx_enable,
	output logic [LINES-1:0] terminal_ready,
	output logic [7:0] transmit_char_byte,
	output logic tx_char_load,
	output logic [LINES-1:0] line_break_bit,
	input wire logic [LINES-1:0] tx_serial,
	output logic [LINES-1:0] tx_line_out,
	// Modem pins.
	input wire logic [LINES-1:0] ring_in,
	input wire logic [LINES-1:0] carrier_in,
	// Device reset pulse.
	output logic dev_reset
);
	import mux_regs_pkg::*;

	// ==========================================================
	// Bus decode.
	logic rd_prev_reg;
	logic wr_prev_reg;
	logic wr_rise;
	logic param_write_decode;
	logic rx_buffer_read_decode;
	logic rxbuf_read_reg;
	logic fifo_pop;
	logic [15:0] status_reg;
	logic [15:0] txctrl_reg;
	logic [15:0] txdata_reg;
	logic [15:0] status_next;
	logic [$clog2(RESET_PULSE_CYC+1)-1:0] rst_cnt_reg;
	logic [$clog2(INHIBIT_CYC+1)-1:0] inhib_cnt_reg;
	logic inhibit_active;
	logic [LINES-1:0] ring_s1_reg;
	logic [LINES-1:0] ring_s2_reg;
	logic [LINES-1:0] carr_s1_reg;
	logic [LINES-1:0] carr_s2_reg;
	logic silo_in_ready;
	logic silo_out_valid;
	logic [15:0] silo_out;
	logic [15:0] silo_in;
	scan_phase_t phase_reg;
	logic [$clog2(PHASE_CYC)-1:0] phase_cnt_reg;
	logic pushed_reg;
	logic [LINES-1:0] rx_on_reg;
	logic [3:0] baud_sel_reg [LINES];

	function automatic logic [15:0] merge_bytes(input logic [15:0] old, input logic [15:0] d,
		input logic [1:0] be);
		merge_bytes = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
	endfunction : merge_bytes

	assign wr_rise = bus_write & ~wr_prev_reg;
	assign param_write_decode = wr_rise & (reg_addr[2:1] == ADDR_RXBUF[2:1]) & (byte_en == 2'b11);
	assign rx_buffer_read_decode = bus_read & (reg_addr[2:1] == ADDR_RXBUF[2:1]);
	assign inhibit_active = (inhib_cnt_reg != '0);
	assign dev_reset = (rst_cnt_reg != '0);

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rd_prev_reg <= 1'b0;
			wr_prev_reg <= 1'b0;
			rxbuf_read_reg <= 1'b0;
		end else begin
			rd_prev_reg <= bus_read;
			wr_prev_reg <= bus_write;
			rxbuf_read_reg <= rx_buffer_read_decode;
		end
	end

	// Slave sync is withheld while the parameter hold-off runs.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			bus_slave_sync <= 1'b0;
		end else begin
			bus_slave_sync <= (bus_read | bus_write) & ~param_write_decode & ~inhibit_active;
		end
	end

	// ==========================================================
	// Device reset pulse.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rst_cnt_reg <= '0;
		end else if (bus_init || (status_reg[STATUS_CLR_BIT] && !dev_reset)) begin
			rst_cnt_reg <= ($bits(rst_cnt_reg))'(RESET_PULSE_CYC);
		end else if (dev_reset) begin
			rst_cnt_reg <= rst_cnt_reg - 1'b1;
		end
	end

	// ==========================================================
	// Control-status register.
	always_comb begin
		status_next = status_reg;
		if (wr_rise && reg_addr[2:1] == ADDR_STATUS[2:1]) begin
			status_next = merge_bytes(status_reg, wr_data, byte_en) & STATUS_RW_MASK;
		end
	end

	// The pulse wipes the clear bit as well, so the bit cannot hold the pulse up forever.
	always_ff @(posedge clk_sys) begin
		if (sys_rst || dev_reset) begin
			status_reg <= STATUS_RESET;
		end else begin
			status_reg <= status_next;
		end
	end

	// ==========================================================
	// Transmit control and transmit data.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			txctrl_reg <= TXCTRL_RESET;
		end else begin
			if (wr_rise && reg_addr[2:1] == ADDR_TXCTRL[2:1]) begin
				txctrl_reg <= merge_bytes(txctrl_reg, wr_data, byte_en);
			end
			if (dev_reset) begin
				txctrl_reg[7:0] <= TXCTRL_RESET[7:0];
			end
			if (bus_init) begin
				txctrl_reg[15:8] <= TXCTRL_RESET[15:8];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst || dev_reset) begin
			txdata_reg <= TXDATA_RESET;
			tx_char_load <= 1'b0;
		end else begin
			tx_char_load <= wr_rise & (reg_addr[2:1] == ADDR_MODEM[2:1]) & byte_en[0];
			if (wr_rise && reg_addr[2:1] == ADDR_MODEM[2:1]) begin
				txdata_reg <= merge_bytes(txdata_reg, wr_data, byte_en);
			end
		end
	end

	assign tx_enable = txctrl_reg[LINES-1:0];
	assign terminal_ready = txctrl_reg[8 +: LINES];
	assign transmit_char_byte = txdata_reg[7:0];
	assign line_break_bit = txdata_reg[8 +: LINES];
	assign tx_line_out = tx_serial & ~line_break_bit;

	// ==========================================================
	// Modem pins pass two flip-flops.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ring_s1_reg <= '0;
			ring_s2_reg <= '0;
			carr_s1_reg <= '0;
			carr_s2_reg <= '0;
		end else begin
			ring_s1_reg <= ring_in;
			ring_s2_reg <= ring_s1_reg;
			carr_s1_reg <= carrier_in;
			carr_s2_reg <= carr_s1_reg;
		end
	end

	// ==========================================================
	// Read data; the modem view is live and raises no event; a receive-buffer read pops the silo.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rd_data <= 16'h0000;
		end else if (bus_read) begin
			if (reg_addr[2:1] == ADDR_STATUS[2:1]) begin
				rd_data <= status_reg | (16'(silo_out_valid) << STATUS_READY_BIT);
			end else if (reg_addr[2:1] == ADDR_RXBUF[2:1]) begin
				rd_data <= silo_out_valid ? silo_out : 16'h0000;
			end else if (reg_addr[2:1] == ADDR_TXCTRL[2:1]) begin
				rd_data <= txctrl_reg;
			end else begin
				rd_data <= {8'(carr_s2_reg), 8'(ring_s2_reg)};
			end
		end
	end

	// ==========================================================
	// Line parameters: hold-off, control strobe, baud selection.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			inhib_cnt_reg <= '0;
			line_parameters <= 16'h0000;
		end else if (param_write_decode) begin
			inhib_cnt_reg <= ($bits(inhib_cnt_reg))'(INHIBIT_CYC);
			line_parameters <= wr_data & LP_USED_MASK;
		end else if (inhibit_active) begin
			inhib_cnt_reg <= inhib_cnt_reg - 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			param_strobe <= '0;
		end else begin
			param_strobe <= '0;
			if (inhib_cnt_reg == ($bits(inhib_cnt_reg))'(INHIBIT_CYC - STROBE_AT)) begin
				param_strobe[line_parameters[2:0]] <= 1'b1;
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < LINES; g++) begin : g_line
			logic [11:0] baud_cnt_reg;
			always_ff @(posedge clk_sys) begin
				if (sys_rst) begin
					baud_sel_reg[g] <= 4'h0;
					rx_on_reg[g] <= 1'b0;
				end else if (param_strobe[g]) begin
					baud_sel_reg[g] <= line_parameters[LP_BAUD_LSB +: 4];
					rx_on_reg[g] <= line_parameters[LP_RXON_BIT];
				end
			end
			// Each line divides the system clock independently.
			always_ff @(posedge clk_sys) begin
				if (sys_rst || param_strobe[g]) begin
					baud_cnt_reg <= 12'h000;
					tx_baud_clock[g] <= 1'b0;
				end else if (baud_cnt_reg == 12'((baud_sel_reg[g] + 5'h01) * BAUD_STEP - 1)) begin
					baud_cnt_reg <= 12'h000;
					tx_baud_clock[g] <= 1'b1;
				end else begin
					baud_cnt_reg <= baud_cnt_reg + 12'h001;
					tx_baud_clock[g] <= 1'b0;
				end
			end
			assign rx_baud_clock[g] = tx_baud_clock[g] & rx_on_reg[g];
		end
	endgenerate

	// ==========================================================
	// Scanner: four equal phases per line slot.
	always_ff @(posedge clk_sys) begin
		if (sys_rst || dev_reset || !status_reg[STATUS_SCAN_BIT]) begin
			phase_reg <= PH1;
			phase_cnt_reg <= '0;
			scan_line <= 3'h0;
		end else if (phase_cnt_reg == ($bits(phase_cnt_reg))'(PHASE_CYC - 1)) begin
			phase_cnt_reg <= '0;
			case (phase_reg)
				PH1: begin
					phase_reg <= PH2;
				end
				PH2: begin
					phase_reg <= PH3;
				end
				PH3: begin
					phase_reg <= PH4;
				end
				default: begin
					phase_reg <= PH1;
					scan_line <= scan_line + 3'h1;
				end
			endcase
		end else begin
			phase_cnt_reg <= phase_cnt_reg + 1'b1;
		end
	end

	assign fifo_push = status_reg[STATUS_SCAN_BIT] & (phase_reg == PH2) & (phase_cnt_reg == '0) & silo_in_ready
		& rx_data_available;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pushed_reg <= 1'b0;
			rx_avail_clear <= 1'b0;
		end else begin
			rx_avail_clear <= 1'b0;
			if (fifo_push) begin
				pushed_reg <= 1'b1;
			end else if (pushed_reg && phase_reg == PH3) begin
				pushed_reg <= 1'b0;
				rx_avail_clear <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Silo: pop on the trailing edge of a receive-buffer read.
	assign silo_in = {rx_errors, 1'b0, scan_line, rx_char};
	assign fifo_pop = rxbuf_read_reg & ~bus_read & silo_out_valid;

	rx_silo #(
		.WIDTH(16),
		.DEPTH(DEPTH)
	) u_silo (
		.clk_sys(clk_sys),
		.flush(sys_rst | dev_reset),
		.in_valid(fifo_push),
		.in_ready(silo_in_ready),
		.in_data(silo_in),
		.out_valid(silo_out_valid),
		.out_ready(fifo_pop),
		.out_data(silo_out)
	);

	// ==========================================================
	// Checks.
	a_push_phase: assert property (@(posedge clk_sys) disable iff (sys_rst)
		fifo_push |-> phase_reg == PH2 && rx_data_available && silo_in_ready)
		else $error("push outside phase 2");
	a_pop_trailing: assert property (@(posedge clk_sys) disable iff (sys_rst)
		fifo_pop |-> $past(bus_read) && !bus_read && silo_out_valid)
		else $error("pop not at read trailing edge");
	a_inhibit_sync: assert property (@(posedge clk_sys) disable iff (sys_rst)
		param_write_decode |=> !bus_slave_sync [*8])
		else $error("slave sync during hold-off");
	a_strobe_mid: assert property (@(posedge clk_sys) disable iff (sys_rst)
		param_write_decode |-> ##7 (param_strobe != '0))
		else $error("control strobe not midway");
	a_reset_pulse: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$rose(dev_reset) |-> dev_reset [*8])
		else $error("device reset pulse too short");
	a_break_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(tx_line_out & line_break_bit) == '0)
		else $error("break line not held at zero");
	a_status_mask: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(status_reg & ~STATUS_RW_MASK) == 16'h0000)
		else $error("unused status bit stored");
	a_ready_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
		dev_reset && !bus_init && !wr_rise |=> txctrl_reg[15:8] == $past(txctrl_reg[15:8]))
		else $error("ready flags cleared by device reset");
	a_rx_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
		param_strobe[0] |=> rx_on_reg[0] == $past(line_parameters[LP_RXON_BIT]))
		else $error("receiver-on not latched");
	a_lp_latch: assert property (@(posedge clk_sys) disable iff (sys_rst)
		param_strobe[0] |=> baud_sel_reg[0] == $past(line_parameters[11:8]))
		else $error("baud select not latched");
endmodule : eight_line_async_mux_regs

`default_nettype wire

// ### hdl/mux_regs_pkg.sv
package mux_regs_pkg;
	// ==========================================================
	// Register addresses (byte address, bit 0 ignored).
	localparam logic [2:0] ADDR_STATUS = 3'h0;
	localparam logic [2:0] ADDR_RXBUF = 3'h2;
	localparam logic [2:0] ADDR_TXCTRL = 3'h4;
	localparam logic [2:0] ADDR_MODEM = 3'h6;
	// ==========================================================
	// Field layouts.
	localparam logic [15:0] STATUS_RW_MASK = 16'h5078;
	localparam int STATUS_CLR_BIT = 4;
	localparam int STATUS_SCAN_BIT = 5;
	localparam int STATUS_READY_BIT = 7;
	localparam int LP_BAUD_LSB = 8;
	localparam int LP_RXON_BIT = 12;
	localparam logic [15:0] LP_USED_MASK = 16'h1fff;
	localparam int RB_LINE_LSB = 8;
	localparam int RB_ERR_LSB = 12;
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	localparam logic [15:0] TXCTRL_RESET = 16'h0000;
	localparam logic [15:0] TXDATA_RESET = 16'h0000;
	// ==========================================================
	// Timing.
	localparam int CLK_MHZ = 20;
	localparam int RESET_PULSE_US = 15;
	localparam int RESET_PULSE_CYC = RESET_PULSE_US * CLK_MHZ;
	localparam int INHIBIT_NS = 500;
	localparam int INHIBIT_CYC = INHIBIT_NS * CLK_MHZ / 1000;
	localparam int STROBE_AT = INHIBIT_CYC / 2;
	localparam int SLOT_NS = 4000;
	localparam int PHASE_CYC = SLOT_NS * CLK_MHZ / 1000 / 4;
	localparam int BAUD_STEP = 16;
	localparam int NUM_LINES = 8;
	localparam int SILO_DEPTH = 64;
	// ==========================================================
	// Scan phases, Gray coded.
	typedef enum logic [1:0] {
		PH1 = 2'b00,
		PH2 = 2'b01,
		PH3 = 2'b11,
		PH4 = 2'b10
	} scan_phase_t;
endpackage : mux_regs_pkg

// ### tb/host_model.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Host processor on the register port.
module host_model (
	// Clock.
	input wire logic clk_sys,
	// Register port.
	output logic [2:0] reg_addr,
	output logic bus_read,
	output logic bus_write,
	output logic [1:0] byte_en,
	output logic [15:0] wr_data,
	input wire logic [15:0] rd_data,
	input wire logic bus_slave_sync
);
	int waited;
	initial begin
		reg_addr = 3'h0;
		bus_read = 1'b0;
		bus_write = 1'b0;
		byte_en = 2'h0;
		wr_data = 16'h0000;
	end
	// The strobe and its qualifiers hold until the reply is sampled; released address and data lines show the inverse.
	task automatic cycle(input logic wr, input logic [2:0] a, input logic [1:0] be, input logic [15:0] d,
			output logic [15:0] q);
		waited = 0;
		reg_addr <= a;
		byte_en <= be;
		wr_data <= d;
		bus_write <= wr;
		bus_read <= !wr;
		do begin
			@(posedge clk_sys);
			waited++;
		end while (bus_slave_sync !== 1'b1 && waited < 40);
		q = rd_data;
		bus_write <= 1'b0;
		bus_read <= 1'b0;
		wr_data <= ~d;
		reg_addr <= ~a;
		repeat (2) @(posedge clk_sys);
	endtask : cycle
endmodule : host_model

`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ns
`default_nettype none

module tb;
	import mux_regs_pkg::*;
	localparam int D = 8;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic bus_init = 1'b0;
	logic rx_data_available = 1'b0;
	logic [7:0] rx_char = 8'h00;
	logic [3:0] rx_errors = 4'h0;
	logic [7:0] tx_serial = 8'h00, ring_in = 8'h00, carrier_in = 8'h00, rxon = 8'h00, bad, sval;
	logic [2:0] reg_addr, scan_line;
	logic bus_read, bus_write, bus_slave_sync, fifo_push, rx_avail_clear, tx_char_load, dev_reset, wr_q;
	logic [1:0] byte_en;
	logic [15:0] wr_data, rd_data, line_parameters, q, w;
	logic [7:0] param_strobe, tx_baud_clock, rx_baud_clock, tx_enable, terminal_ready, transmit_char_byte;
	logic [7:0] line_break_bit, tx_line_out;
	logic [31:0] rs = 32'd95;
	int errors = 0, tests_run = 0, cyc = 0, wcyc, scyc, pcyc, pgap, npush = 0, drc = 0, n, ndac = 0, nld = 0;
	logic [15:0] silo_q[$];

	always #25 clk_sys = ~clk_sys;

	eight_line_async_mux_regs #(.DEPTH(D)) dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .bus_read(bus_read), .bus_write(bus_write), .byte_en(byte_en),
		.wr_data(wr_data), .rd_data(rd_data), .bus_slave_sync(bus_slave_sync), .bus_init(bus_init),
		.scan_line(scan_line), .rx_data_available(rx_data_available), .rx_char(rx_char),
		.rx_errors(rx_errors), .fifo_push(fifo_push), .rx_avail_clear(rx_avail_clear),
		.line_parameters(line_parameters), .param_strobe(param_strobe), .tx_baud_clock(tx_baud_clock),
		.rx_baud_clock(rx_baud_clock), .tx_enable(tx_enable), .terminal_ready(terminal_ready),
		.transmit_char_byte(transmit_char_byte), .tx_char_load(tx_char_load),
		.line_break_bit(line_break_bit), .tx_serial(tx_serial), .tx_line_out(tx_line_out),
		.ring_in(ring_in), .carrier_in(carrier_in), .dev_reset(dev_reset));

	host_model host_u (.clk_sys(clk_sys), .reg_addr(reg_addr), .bus_read(bus_read), .bus_write(bus_write),
		.byte_en(byte_en), .wr_data(wr_data), .rd_data(rd_data), .bus_slave_sync(bus_slave_sync));

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [2:0] a, input logic [1:0] be, input logic [15:0] d);
		host_u.cycle(1'b1, a, be, d, q);
		chk(16'(host_u.waited < 40), 16'h0001);
	endtask : wr

	task automatic rd(input logic [2:0] a, input logic [15:0] exp);
		host_u.cycle(1'b0, a, 2'h3, 16'h0000, q);
		chk(q, exp);
	endtask : rd

	task automatic baud(input int ln, input int per);
		n = 0;
		while (!tx_baud_clock[ln] && n < 400) begin
			@(posedge clk_sys);
			n++;
		end
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (!tx_baud_clock[ln] && n < 400);
		chk(16'(n), 16'(per));
	endtask : baud

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test

	// ==========================================================
	// Monitors, silo reference model and random input drive.
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		wr_q <= bus_write;
		if (bus_write && !wr_q)
			wcyc <= cyc;
		if (|param_strobe) begin
			scyc <= cyc;
			sval <= param_strobe;
		end
		if (dev_reset)
			drc <= drc + 1;
		if (rx_avail_clear)
			ndac <= ndac + 1;
		if (tx_char_load)
			nld <= nld + 1;
		if (fifo_push && !sys_rst) begin
			silo_q.push_back({rx_errors, 1'b0, scan_line, rx_char});
			pgap <= cyc - pcyc;
			pcyc <= cyc;
			npush <= npush + 1;
		end
		rs = xs(rs);
		rx_char <= rs[7:0];
		rx_errors <= rs[11:8];
		tx_serial <= rs[23:16];
	end

	initial begin
		#(20000 * 50);
		errors++;
		end_of_test();
	end

	// ==========================================================
	// Main sequence.
	initial begin
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		rd(ADDR_STATUS, STATUS_RESET);
		rd(ADDR_TXCTRL, TXCTRL_RESET);
		chk({line_break_bit, transmit_char_byte}, TXDATA_RESET);
		wr(ADDR_STATUS, 2'h3, 16'hffcf);
		rd(ADDR_STATUS, 16'hffcf & STATUS_RW_MASK);
		wr(ADDR_STATUS, 2'h1, 16'h0000);
		rd(ADDR_STATUS, 16'h5000);
		wr(ADDR_STATUS, 2'h2, 16'h00ff);
		rd(ADDR_STATUS, 16'h0000);
		wr(ADDR_TXCTRL, 2'h3, 16'ha55a);
		rd(ADDR_TXCTRL, 16'ha55a);
		wr(ADDR_TXCTRL, 2'h2, 16'h3c00);
		chk({terminal_ready, tx_enable}, 16'h3c5a);
		$display("test registers done");
		wr(ADDR_MODEM, 2'h3, {8'h0f, 8'h41 & 8'h7f});
		chk({line_break_bit, transmit_char_byte}, 16'h0f41);
		repeat (4) begin
			@(negedge clk_sys);
			chk({8'h00, tx_line_out}, {8'h00, tx_serial & 8'hf0});
		end
		wr(ADDR_MODEM, 2'h2, 16'h8000);
		chk({line_break_bit, transmit_char_byte}, 16'h8041);
		chk(16'(nld), 16'h0001);
		ring_in <= rs[7:0];
		carrier_in <= rs[15:8];
		repeat (4) @(posedge clk_sys);
		rd(ADDR_MODEM, {carrier_in, ring_in});
		$display("test transmit_and_modem done");
		for (int i = 0; i < 3; i++) begin
			w = (i == 0) ? 16'h1f00 : (i == 1) ? 16'h12db : 16'he0a5;
			wr(ADDR_RXBUF, 2'h3, w);
			rxon[w[2:0]] = w[LP_RXON_BIT];
			chk(16'(host_u.waited > 10), 16'h0001);
			chk({8'h00, sval}, 16'(1 << w[2:0]));
			chk(16'((scyc - wcyc) inside {[4:7]}), 16'h0001);
			chk(line_parameters, w & LP_USED_MASK);
		end
		wr(ADDR_RXBUF, 2'h1, 16'h0007);
		chk(line_parameters, 16'he0a5 & LP_USED_MASK);
		baud(3, 3 * BAUD_STEP);
		baud(5, BAUD_STEP);
		bad = 8'h00;
		repeat (300) begin
			@(negedge clk_sys);
			bad = bad | (rx_baud_clock ^ (tx_baud_clock & rxon));
		end
		chk({8'h00, bad}, 16'h0000);
		$display("test line_parameters done");
		rx_data_available <= 1'b1;
		wr(ADDR_STATUS, 2'h3, 16'h0020);
		n = 0;
		while (npush < D && n < 2000) begin
			@(posedge clk_sys);
			n++;
		end
		repeat (240) @(posedge clk_sys);
		rx_data_available <= 1'b0;
		chk(16'(npush), 16'(D));
		chk(16'(ndac), 16'(D));
		chk(16'(pgap), 16'(4 * PHASE_CYC));
		rd(ADDR_STATUS, 16'h00a0);
		wr(ADDR_STATUS, 2'h3, 16'h0000);
		repeat (D) rd(ADDR_RXBUF, silo_q.pop_front());
		rd(ADDR_RXBUF, 16'h0000);
		rd(ADDR_STATUS, 16'h0000);
		$display("test silo done");
		wr(ADDR_TXCTRL, 2'h3, 16'ha55a);
		wr(ADDR_MODEM, 2'h3, 16'hff7f);
		drc = 0;
		wr(ADDR_STATUS, 2'h1, 16'h0010);
		repeat (400) @(posedge clk_sys);
		chk(16'(drc), 16'(RESET_PULSE_CYC));
		rd(ADDR_STATUS, STATUS_RESET);
		rd(ADDR_TXCTRL, 16'ha500);
		chk({line_break_bit, transmit_char_byte}, TXDATA_RESET);
		bus_init <= 1'b1;
		@(posedge clk_sys);
		bus_init <= 1'b0;
		drc = 0;
		repeat (400) @(posedge clk_sys);
		chk(16'(drc), 16'(RESET_PULSE_CYC));
		rd(ADDR_TXCTRL, 16'h0000);
		$display("test device_reset done");
		end_of_test();
	end
endmodule : tb

`default_nettype wire
